// ==== rtl/mmfc_check.sv ====
// Fault checker and translation buffer pointer former with APB registers
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module mmfc_check
    import mmfc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Core state
    input  wire logic        privileged_mode_bit,
    input  wire logic        address_mask_bit,
    // Pipeline access and fault report
    input  wire mmfc_req_s   req,
    output mmfc_rpt_s        rpt,
    // Buffer pointers and legacy tag
    output logic      [63:0] first_page_size_pointer,
    output logic      [63:0] second_page_size_pointer,
    output logic      [41:0] legacy_tag,
    // Interrupt
    output logic             irq
);
    // Software registers
    logic [2:0]          ctrl;
    logic [3:0]          tsb_size;
    logic [63:0]         tsb_base;
    logic [63:0]         watch_va;
    logic [MMFC_EV_W-1:0] status;
    logic [MMFC_EV_W-1:0] mask;
    logic [63:0]         last_va;

    // APB strobes; access takes two cycles, answered by pready
    wire       acc    = psel && penable && !pready;
    wire       wr_en  = psel && penable && pready && pwrite;
    wire       hit_ctrl  = (paddr == MMFC_OFS_CTRL);
    wire       hit_size  = (paddr == MMFC_OFS_TSB_CFG);
    wire       hit_blo   = (paddr == MMFC_OFS_BASE_LO);
    wire       hit_bhi   = (paddr == MMFC_OFS_BASE_HI);
    wire       hit_wlo   = (paddr == MMFC_OFS_WATCH_LO);
    wire       hit_whi   = (paddr == MMFC_OFS_WATCH_HI);
    wire       hit_stat  = (paddr == MMFC_OFS_STATUS);
    wire       hit_mask  = (paddr == MMFC_OFS_MASK);
    wire       hit_llo   = (paddr == MMFC_OFS_LASTVA_LO);
    wire       hit_lhi   = (paddr == MMFC_OFS_LASTVA_HI);
    wire       hit_any   = hit_ctrl | hit_size | hit_blo | hit_bhi
                         | hit_wlo | hit_whi | hit_stat | hit_mask
                         | hit_llo | hit_lhi;
    wire       bad_wr    = pwrite && (hit_stat ? 1'b0 : (hit_llo|hit_lhi));
    logic [31:0] rd_mux;

    // Read selection
    always_comb begin
        if (hit_ctrl)      rd_mux = {29'h0, ctrl};
        else if (hit_size) rd_mux = {28'h0, tsb_size};
        else if (hit_blo)  rd_mux = tsb_base[31:0];
        else if (hit_bhi)  rd_mux = tsb_base[63:32];
        else if (hit_wlo)  rd_mux = watch_va[31:0];
        else if (hit_whi)  rd_mux = watch_va[63:32];
        else if (hit_stat) rd_mux = {27'h0, status};
        else if (hit_mask) rd_mux = {27'h0, mask};
        else if (hit_llo)  rd_mux = last_va[31:0];
        else if (hit_lhi)  rd_mux = last_va[63:32];
        else               rd_mux = 32'h0;
    end

    // APB answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc;
            prdata  <= (acc && !pwrite) ? rd_mux : 32'h0;
            pslverr <= acc && (!hit_any || bad_wr);
        end
    end

    // Writable configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= MMFC_CTRL_RESET;
            tsb_size <= MMFC_SIZE_RESET;
            tsb_base <= 64'h0;
            watch_va <= 64'h0;
            mask     <= '0;
        end else if (wr_en) begin
            if (hit_ctrl) ctrl     <= pwdata[2:0];
            if (hit_size) tsb_size <= pwdata[3:0];
            if (hit_blo)  tsb_base[31:0]  <= pwdata;
            if (hit_bhi)  tsb_base[63:32] <= pwdata;
            if (hit_wlo)  watch_va[31:0]  <= pwdata;
            if (hit_whi)  watch_va[63:32] <= pwdata;
            if (hit_mask) mask <= pwdata[MMFC_EV_W-1:0];
        end
    end

    // Pointer formation
    wire [5:0]  n_raw   = {2'h0, tsb_size} + {1'b0, MMFC_MIN_LOG2};
    wire [4:0]  n_log2  = (n_raw > {1'b0, MMFC_MAX_LOG2}) ? MMFC_MAX_LOG2
                                                          : n_raw[4:0];
    wire [63:0] idx_mask = (64'h1 << n_log2) - 64'h1;
    wire [63:0] vpn0    = req.va >> MMFC_PS0_SHIFT;
    wire [63:0] vpn1    = req.va >> MMFC_PS1_SHIFT;
    wire [63:0] off0    = (vpn0 & idx_mask) << MMFC_ENTRY_LOG2;
    wire [63:0] off1    = (vpn1 & idx_mask) << MMFC_ENTRY_LOG2;
    wire [63:0] half    = 64'h1 << (n_log2 + MMFC_ENTRY_LOG2);
    wire [63:0] base1   = ctrl[MMFC_CTRL_SPLIT] ? tsb_base + half
                                                : tsb_base;
    // Only two page sizes get hardware pointers
    wire [63:0] next_p0 = tsb_base + off0;
    wire [63:0] next_p1 = base1 + off1;

    // Range, masking and sign extension of the access address
    wire        upper_same = (&req.va[63:MMFC_VA_MSB])
                           | ~(|req.va[63:MMFC_VA_MSB]);
    wire        out_range  = !address_mask_bit && !upper_same;
    wire [63:0] va_sx   = {{16{req.va[MMFC_VA_MSB]}},
                           req.va[MMFC_VA_MSB:0]};
    wire [63:0] va_out  = address_mask_bit ? {32'h0, req.va[31:0]}
                                           : va_sx;

    // Data fault causes, each raised independently
    wire        dacc     = req.valid && !req.fetch;
    wire        user     = !privileged_mode_bit;
    wire        restr    = dacc && req.alt && req.restricted && user;
    logic [MMFC_C_W-1:0] causes;
    assign causes[MMFC_C_PRIV]  = dacc && req.pg_priv && user;
    assign causes[MMFC_C_SIDE]  = dacc && req.nf_load && req.pg_side;
    assign causes[MMFC_C_ATOM]  = dacc && req.atomic
                                && req.va[MMFC_IO_BIT];
    assign causes[MMFC_C_ASI]   = dacc && req.alt && !restr
                                && (req.asi_bad || req.asi_va_bad
                                    || req.rd_wonly || req.wr_ronly);
    assign causes[MMFC_C_NFO]   = dacc && req.pg_nfo
                                && !(req.alt && req.nf_space);
    assign causes[MMFC_C_RANGE] = dacc && out_range;

    // Fetch, alignment and watch checks
    wire        ifault  = req.valid && req.fetch && ctrl[MMFC_CTRL_FETCH_EN]
                        && ((req.pg_priv && user) || out_range);
    wire [2:0]  alow    = req.va[2:0] & ((3'h1 << req.size_log2) - 3'h1);
    wire        alfault = req.valid && (req.load || req.store
                        || req.atomic || req.jump_and_link_ret) && (alow != 3'h0);
    wire        watch   = dacc && ctrl[MMFC_CTRL_WATCH_EN]
                        && (req.load || req.store)
                        && (va_sx == watch_va);
    wire        dfault  = |causes;

    // One type code per report; causes carry every data indication
    mmfc_fault_e next_type;
    always_comb begin
        if (alfault)      next_type = MMFC_FT_ALIGN;
        else if (restr)   next_type = MMFC_FT_RESTRICT;
        else if (ifault)  next_type = MMFC_FT_INSTR;
        else if (dfault)  next_type = MMFC_FT_DATA;
        else if (watch)   next_type = MMFC_FT_WATCH;
        else              next_type = MMFC_FT_NONE;
    end
    wire [MMFC_EV_W-1:0] ev = {watch, restr, alfault, ifault, dfault};

    // Report and pointer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rpt                      <= '0;
            first_page_size_pointer  <= 64'h0;
            second_page_size_pointer <= 64'h0;
            legacy_tag               <= 42'h0;
            last_va                  <= 64'h0;
        end else begin
            rpt.valid  <= next_type != MMFC_FT_NONE;
            rpt.ftype  <= next_type;
            rpt.causes <= causes;
            rpt.addr   <= va_out;
            if (req.valid) begin
                first_page_size_pointer  <= next_p0;
                second_page_size_pointer <= next_p1;
                legacy_tag <= va_out[63:MMFC_TAG_LSB];
            end
            if (next_type != MMFC_FT_NONE) last_va <= va_out;
        end
    end

    // Sticky status, set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
            irq    <= 1'b0;
        end else begin
            status <= (status & ~((wr_en && hit_stat)
                                  ? pwdata[MMFC_EV_W-1:0] : '0)) | ev;
            irq    <= |(status & mask);
        end
    end

    // Checks on the design's own outputs and internal signals
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_PRIV_DATA: assert property (
        dacc && req.pg_priv && user && !restr && !alfault && !ifault
        |=> rpt.valid && rpt.ftype == MMFC_FT_DATA && rpt.causes[0])
        else $error("privileged page access not reported");
    AST_SIDE: assert property (
        dacc && req.nf_load && req.pg_side |=> rpt.causes[MMFC_C_SIDE])
        else $error("side-effect cause missing");
    AST_ATOM_IO: assert property (
        dacc && req.atomic && req.va[39] |=> rpt.causes[MMFC_C_ATOM])
        else $error("atomic to I/O not flagged");
    AST_RESTRICT: assert property (
        restr && !alfault |=> rpt.ftype == MMFC_FT_RESTRICT
                              && !rpt.causes[MMFC_C_ASI])
        else $error("restricted space handled as data fault");
    AST_FETCH_OFF: assert property (
        !ctrl[MMFC_CTRL_FETCH_EN] |-> !ifault)
        else $error("fetch fault while fetch unit disabled");
    AST_MASK_HI: assert property (
        address_mask_bit && req.valid |=> rpt.addr[63:32] == 32'h0)
        else $error("masked address has upper bits set");
    AST_SIGN_EXT: assert property (
        !address_mask_bit |=> rpt.addr[63:48] == {16{rpt.addr[47]}})
        else $error("address not sign extended");
    AST_STICKY: assert property (
        status[MMFC_EV_DATA] && !(wr_en && hit_stat)
        |=> status[MMFC_EV_DATA])
        else $error("status bit dropped without clear");
    AST_IRQ: assert property (
        |(status & mask) |=> irq)
        else $error("interrupt not raised");
    AST_PTR_SHARED: assert property (
        req.valid && !ctrl[MMFC_CTRL_SPLIT] && tsb_size == 4'h0
        |=> (second_page_size_pointer - $past(tsb_base)) < 64'h2000)
        else $error("shared pointer left the 8K buffer");
    AST_APB_WAIT: assert property (
        psel && !penable |=> ##1 pready)
        else $error("APB answer late");

    COV_DATA: cover property (rpt.ftype == MMFC_FT_DATA
                              && $countones(rpt.causes) > 1);
    COV_ALIGN: cover property (rpt.ftype == MMFC_FT_ALIGN);
    COV_WATCH: cover property (rpt.ftype == MMFC_FT_WATCH);
    COV_SPLIT: cover property (req.valid && ctrl[MMFC_CTRL_SPLIT]);
endmodule : mmfc_check

// ==== rtl/mmfc_pkg.sv ====
// Constants, types and register map for the translation fault checker
package mmfc_pkg;
    // APB register byte offsets
    localparam logic [7:0] MMFC_OFS_CTRL     = 8'h00;
    localparam logic [7:0] MMFC_OFS_TSB_CFG  = 8'h04;
    localparam logic [7:0] MMFC_OFS_BASE_LO  = 8'h08;
    localparam logic [7:0] MMFC_OFS_BASE_HI  = 8'h0C;
    localparam logic [7:0] MMFC_OFS_WATCH_LO = 8'h10;
    localparam logic [7:0] MMFC_OFS_WATCH_HI = 8'h14;
    localparam logic [7:0] MMFC_OFS_STATUS   = 8'h18;
    localparam logic [7:0] MMFC_OFS_MASK     = 8'h1C;
    localparam logic [7:0] MMFC_OFS_LASTVA_LO = 8'h20;
    localparam logic [7:0] MMFC_OFS_LASTVA_HI = 8'h24;
    // Control register fields
    localparam int MMFC_CTRL_SPLIT    = 0;
    localparam int MMFC_CTRL_WATCH_EN = 1;
    localparam int MMFC_CTRL_FETCH_EN = 2;
    localparam logic [2:0] MMFC_CTRL_RESET = 3'h0;
    localparam logic [3:0] MMFC_SIZE_RESET = 4'h0;
    // Buffer geometry: 512 entries (2^9) up to 16M entries (2^24)
    localparam logic [4:0] MMFC_MIN_LOG2 = 5'h09;
    localparam logic [4:0] MMFC_MAX_LOG2 = 5'h18;
    localparam logic [4:0] MMFC_ENTRY_LOG2 = 5'h04;
    // Page shifts for the two hardware-indexed page sizes
    localparam int MMFC_PS0_SHIFT = 13;
    localparam int MMFC_PS1_SHIFT = 22;
    // Legacy tag keeps bits 63:22, dropping 21:13
    localparam int MMFC_TAG_LSB = 22;
    // Implemented virtual address width and top bit
    localparam int MMFC_VA_MSB = 47;
    localparam int MMFC_IO_BIT = 39;
    // Status / mask bit positions
    localparam int MMFC_EV_DATA  = 0;
    localparam int MMFC_EV_INSTR = 1;
    localparam int MMFC_EV_ALIGN = 2;
    localparam int MMFC_EV_PRIV  = 3;
    localparam int MMFC_EV_WATCH = 4;
    localparam int MMFC_EV_W     = 5;
    // Data fault cause bits
    localparam int MMFC_C_PRIV  = 0;
    localparam int MMFC_C_SIDE  = 1;
    localparam int MMFC_C_ATOM  = 2;
    localparam int MMFC_C_ASI   = 3;
    localparam int MMFC_C_NFO   = 4;
    localparam int MMFC_C_RANGE = 5;
    localparam int MMFC_C_W     = 6;

    typedef enum logic [2:0] {
        MMFC_FT_NONE, MMFC_FT_DATA, MMFC_FT_INSTR,
        MMFC_FT_ALIGN, MMFC_FT_RESTRICT, MMFC_FT_WATCH
    } mmfc_fault_e;

    // Access presented by the fetch or load/store pipeline
    typedef struct packed {
        logic        valid;
        logic        fetch;
        logic        load;
        logic        store;
        logic        atomic;
        logic        jump_and_link_ret;     // jump_and_link or return target
        logic        nf_load;      // speculative non-faulting load
        logic [1:0]  size_log2;    // access size as log2 of bytes
        logic [63:0] va;
        logic        pg_priv;      // page mapping entry privileged bit
        logic        pg_side;      // side-effect bit
        logic        pg_nfo;       // no-fault-only bit
        logic        alt;          // alternate_space_id access
        logic        asi_bad;      // invalid alternate_space_id
        logic        asi_va_bad;   // invalid VA for that space
        logic        rd_wonly;     // read of a write-only register
        logic        wr_ronly;     // write of a read-only register
        logic        restricted;   // restricted alternate space
        logic        nf_space;     // primary/secondary no-fault space
    } mmfc_req_s;

    // Fault report to the trap logic
    typedef struct packed {
        logic              valid;
        mmfc_fault_e       ftype;
        logic [MMFC_C_W-1:0] causes;
        logic [63:0]       addr;   // masked / sign-extended address
    } mmfc_rpt_s;
endpackage : mmfc_pkg

// ==== tb/mmfc_check_tb.sv ====
// Self-checking bench for the fault checker and pointer former
`timescale 1ns/1ps
module mmfc_check_tb;
    import mmfc_pkg::*;
    // Bench signals
    logic        pclk, presetn, psel, penable, pwrite;
    logic        pready, pslverr, irq, pv, am, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [63:0] p0, p1, base, va, wva;
    logic [41:0] ltag;
    logic [2:0]  ctrl;
    mmfc_req_s   req, r;
    mmfc_rpt_s   rpt;
    int          miscompares, checks_done;
    // Design and pipeline model
    mmfc_check i_mmfc_check (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .privileged_mode_bit(pv), .address_mask_bit(am), .req(req),
        .rpt(rpt), .first_page_size_pointer(p0),
        .second_page_size_pointer(p1), .legacy_tag(ltag), .irq(irq));
    mmfc_pipe_model i_mmfc_pipe_model (.pclk(pclk), .req(req),
        .privileged_mode_bit(pv), .address_mask_bit(am));
    // Clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Compare and count
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Verdict and end of run
    task automatic close_out();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Look at the answer mid-cycle, where it is settled
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        e = pslverr;
        // Release only after the edge that samples pready high
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            miscompares++;
            close_out();
        end
    endtask : apb
    // Register read with expected data and error flag
    task automatic rdc(input logic [7:0] a, input logic [31:0] x,
                       input logic xe);
        apb(1'b0, a, 32'h0);
        chk(rd, x);
        chk(e, xe);
    endtask : rdc
    // Access of kind k at v, 8 bytes (4 for jump): fetch, load, store, atomic, jump
    function automatic mmfc_req_s mk(input int k, input logic [63:0] v);
        mmfc_req_s q;
        q = '0;
        q.valid = 1'b1;
        {q.fetch, q.load, q.store, q.atomic, q.jump_and_link_ret} = 5'h10 >> k;
        q.size_log2 = (k == 4) ? 2'h2 : 2'h3;
        q.va = v;
        return q;
    endfunction : mk
    // Expected fault report for one access
    function automatic mmfc_rpt_s exp_rpt(input mmfc_req_s q,
                                          input logic p, input logic m);
        mmfc_rpt_s   x;
        logic [63:0] sx;
        logic        d, oor, rs, mis, ins, wh;
        logic [2:0]  lm;
        sx = {{16{q.va[47]}}, q.va[47:0]};
        oor = !m && (sx != q.va);
        d = q.load || q.store || q.atomic;
        rs = d && q.alt && q.restricted && !p;
        x = '0;
        x.causes[MMFC_C_PRIV] = d && q.pg_priv && !p;
        x.causes[MMFC_C_SIDE] = d && q.nf_load && q.pg_side;
        x.causes[MMFC_C_ATOM] = d && q.atomic && q.va[MMFC_IO_BIT];
        x.causes[MMFC_C_ASI] = d && q.alt && !rs && (q.asi_bad ||
            q.asi_va_bad || q.rd_wonly || q.wr_ronly);
        x.causes[MMFC_C_NFO] = d && q.pg_nfo && !(q.alt && q.nf_space);
        x.causes[MMFC_C_RANGE] = d && oor;
        lm = 3'((4'h1 << q.size_log2) - 4'h1);
        mis = (d || q.jump_and_link_ret) && |(q.va[2:0] & lm);
        ins = q.fetch && ctrl[MMFC_CTRL_FETCH_EN]
              && ((q.pg_priv && !p) || oor);
        wh = ctrl[MMFC_CTRL_WATCH_EN] && (q.load || q.store) && sx == wva;
        x.ftype = mis ? MMFC_FT_ALIGN : rs ? MMFC_FT_RESTRICT :
                  ins ? MMFC_FT_INSTR : |x.causes ? MMFC_FT_DATA :
                  wh ? MMFC_FT_WATCH : MMFC_FT_NONE;
        x.valid = (x.ftype != MMFC_FT_NONE);
        x.addr = m ? {32'h0, q.va[31:0]} : sx;
        return x;
    endfunction : exp_rpt
    // Expected pointer for size field s, layout sp, page size w
    function automatic logic [63:0] ptr(input int s, input logic sp,
                                        input logic w);
        int          n;
        logic [63:0] b;
        n = (9 + s > 24) ? 24 : 9 + s;
        b = (w && sp) ? base + (64'h1 << (n + 4)) : base;
        return b + (((va >> (w ? MMFC_PS1_SHIFT : MMFC_PS0_SHIFT))
                    & ((64'h1 << n) - 64'h1)) << 4);
    endfunction : ptr
    // Issue one access and check the report a cycle later
    task automatic run(input mmfc_req_s q, input logic p, input logic m);
        mmfc_rpt_s x;
        x = exp_rpt(q, p, m);
        i_mmfc_pipe_model.issue(q, p, m);
        // Report stands from the edge after the access to the next one
        @(negedge pclk);
        chk(rpt.valid, x.valid);
        chk(rpt.ftype, x.ftype);
        if (x.valid) begin
            chk(rpt.causes, x.causes);
            chk(rpt.addr, x.addr);
        end
    endtask : run
    // Reset, then directed and random scenarios
    initial begin
        void'($urandom(32'h3b18));
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        miscompares = 0;
        checks_done = 0;
        ctrl = 3'h0;
        wva = 64'h0000_1234_5678_9AB0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc(MMFC_OFS_CTRL, 32'h0, 1'b0);
        rdc(MMFC_OFS_STATUS, 32'h0, 1'b0);
        rdc(8'h40, 32'h0, 1'b1);
        apb(1'b1, MMFC_OFS_LASTVA_LO, 32'hFFFF_FFFF);
        chk(e, 1'b1);
        // Pointers over every size field value and both layouts
        for (int s = 0; s < 16; s++) begin
            base = {$urandom, $urandom};
            va = {$urandom, $urandom};
            va = {{16{va[47]}}, va[47:3], 3'h0};
            apb(1'b1, MMFC_OFS_CTRL, {31'h0, s[0]});
            apb(1'b1, MMFC_OFS_TSB_CFG, 32'(s));
            apb(1'b1, MMFC_OFS_BASE_LO, base[31:0]);
            apb(1'b1, MMFC_OFS_BASE_HI, base[63:32]);
            run(mk(1, va), 1'b1, 1'b0);
            chk(p0, ptr(s, s[0], 1'b0));
            chk(p1, ptr(s, s[0], 1'b1));
            chk(64'(ltag), 64'(va[63:22]));
        end
        // Directed faults with fetch checks and watch enabled, then with both disabled
        ctrl = 3'h6;
        apb(1'b1, MMFC_OFS_CTRL, {29'h0, ctrl});
        apb(1'b1, MMFC_OFS_WATCH_LO, wva[31:0]);
        apb(1'b1, MMFC_OFS_WATCH_HI, wva[63:32]);
        r = mk(1, 64'h0000_8000_0000_1000);
        r.pg_priv = 1'b1;
        run(r, 1'b0, 1'b1);
        run(r, 1'b1, 1'b0);
        rdc(MMFC_OFS_LASTVA_HI, 32'hFFFF_8000, 1'b0);
        r = mk(1, 64'h1000);
        r.nf_load = 1'b1;
        r.pg_side = 1'b1;
        run(r, 1'b1, 1'b0);
        run(mk(3, 64'h80_0000_0000), 1'b1, 1'b0);
        for (int k = 0; k < 4; k++) begin
            r = mk(2, 64'h2000);
            r.alt = 1'b1;
            {r.asi_bad, r.asi_va_bad, r.rd_wonly, r.wr_ronly} = 4'h8 >> k;
            run(r, 1'b1, 1'b0);
        end
        r.restricted = 1'b1;
        run(r, 1'b0, 1'b0);
        run(r, 1'b1, 1'b0);
        r = mk(1, 64'h3000);
        r.pg_nfo = 1'b1;
        run(r, 1'b1, 1'b0);
        r.alt = 1'b1;
        r.nf_space = 1'b1;
        run(r, 1'b1, 1'b0);
        r = mk(3, 64'h80_0000_3000);
        r.pg_priv = 1'b1;
        r.pg_nfo = 1'b1;
        run(r, 1'b0, 1'b0);
        run(mk(0, 64'h0000_8000_0000_0000), 1'b1, 1'b0);
        for (int k = 1; k < 5; k++) run(mk(k, 64'h5002), 1'b1, 1'b0);
        run(mk(1, wva), 1'b1, 1'b0);
        r = mk(0, 64'h4000);
        r.pg_priv = 1'b1;
        run(r, 1'b0, 1'b0);
        ctrl = 3'h0;
        apb(1'b1, MMFC_OFS_CTRL, 32'h0);
        run(r, 1'b0, 1'b0);
        run(mk(2, wva), 1'b1, 1'b0);
        // Random accesses against the expectation function
        ctrl = 3'($urandom);
        apb(1'b1, MMFC_OFS_CTRL, {29'h0, ctrl});
        for (int i = 0; i < 40; i++) begin
            r = mk($urandom % 4, {$urandom, $urandom});
            if (i[0]) r.va = {{16{r.va[47]}}, r.va[47:0]};
            {r.pg_priv, r.pg_side, r.pg_nfo, r.alt, r.asi_bad, r.asi_va_bad,
             r.rd_wonly, r.wr_ronly, r.restricted, r.nf_space} = 10'($urandom);
            r.nf_load = r.load & r.pg_side;
            r.size_log2 = 2'($urandom);
            run(r, 1'($urandom), 1'b0);
        end
        // Interrupt held off by mask, raised on unmask, then cleared
        apb(1'b1, MMFC_OFS_STATUS, 32'h1F);
        apb(1'b1, MMFC_OFS_MASK, 32'h0);
        r = mk(1, 64'h1000);
        r.pg_priv = 1'b1;
        run(r, 1'b0, 1'b0);
        rdc(MMFC_OFS_STATUS, 32'h1, 1'b0);
        chk(irq, 1'b0);
        apb(1'b1, MMFC_OFS_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b1, MMFC_OFS_STATUS, 32'h1);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        close_out();
    end
endmodule : mmfc_check_tb

// ==== tb/mmfc_pipe_model.sv ====
// Pipeline-side model that presents accesses to the checker
`timescale 1ns/1ps
module mmfc_pipe_model
    import mmfc_pkg::*;
(
    // Clock
    input  wire logic pclk,
    // Access toward the checker
    output mmfc_req_s req,
    output logic      privileged_mode_bit,
    output logic      address_mask_bit
);
    // Idle until the first access
    initial begin
        req = '0;
        privileged_mode_bit = 1'b1;
        address_mask_bit = 1'b0;
    end
    // One access for one cycle, then idle with valid cleared and every other field inverted
    task automatic issue(input mmfc_req_s r, input logic pv, input logic m);
        mmfc_req_s idle;
        idle = ~r;
        idle.valid = 1'b0;
        @(posedge pclk);
        req <= r;
        privileged_mode_bit <= pv;
        address_mask_bit <= m;
        @(posedge pclk);
        req <= idle;
    endtask : issue
endmodule : mmfc_pipe_model
